// ==== rtl/acs_pkg.sv ====
// Shared constants and carrier types for the conversion sequencer.
// Assumes a 32-bit APB master and a 10 MHz system clock on mclk.
package acs_pkg;

    // Register indices; the byte address of each is four times its index.
    localparam logic [11:0] IDX_CTL0    = 12'hF70;
    localparam logic [11:0] IDX_CTL1    = 12'hF71;
    localparam logic [11:0] IDX_DATA_HI = 12'hF72;
    localparam logic [11:0] IDX_DATA_LO = 12'hF73;
    localparam logic [11:0] IDX_STAT    = 12'hF74;

    // Control register 0 field positions and reset value.
    localparam int          GO_BIT      = 7;
    localparam int          REF_LO_BIT  = 6;
    localparam int          PIN_DRV_BIT = 5;
    localparam int          REPEAT_BIT  = 4;
    localparam int          SEL_MSB     = 3;
    localparam logic [7:0]  CTL0_RESET  = 8'h00;

    // Control/status register 1: level high bit on top, rest stored only.
    localparam int          REF_HI_BIT  = 7;
    localparam logic [7:0]  CTL1_RESET  = 8'h80;

    // Sequencer status register field positions and reset value.
    localparam int          EN_BIT      = 0;
    localparam int          PWR_BIT     = 1;
    localparam int          BUSY_BIT    = 2;
    localparam logic [7:0]  STAT_RESET  = 8'h01;

    // Low data register layout: raw bits on top, overflow flag at bit 0.
    localparam int          LO_RAW_LSB  = 3;
    localparam int          OVF_BIT     = 0;
    localparam int          RAW_W       = 13;

    // Phase lengths in system clock cycles.
    localparam int          IDLE_CYCLES    = 160;
    localparam int          POWERUP_CYCLES = 40;
    localparam int          CONV_CYCLES    = 5129;
    localparam int          REPEAT_CYCLES  = 256;
    localparam int          CHANNELS       = 8;

    // Sequencer phases, Gray coded along idle, power-up, convert, repeat.
    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_POWERUP = 2'b01,
        PH_CONVERT = 2'b11,
        PH_REPEAT  = 2'b10
    } acs_phase_t;

    // Controls toward the modulator and filter.
    typedef struct packed {
        logic [1:0] refCode;
        logic       refPinDrive;
        logic       powerOn;
        logic       run;
    } acs_fe_ctl_t;

    // Sample word and overflow from the decimation filter.
    typedef struct packed {
        logic [RAW_W-1:0] sample;
        logic             overflow;
    } acs_fe_data_t;

    // Byte address of a register index.
    function automatic logic [15:0] acs_byte_addr(input logic [11:0] idx);
        acs_byte_addr = {2'b00, idx, 2'b00};
    endfunction

endpackage

// ==== rtl/acs_chan_route.sv ====
// Input switch decoder for the analog multiplexer.
// Assumes the select code is stable while the converter runs.
`timescale 1ns/1ns
`default_nettype none
module acs_chan_route (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Selection.
    input  wire logic [3:0] inputSelect,
    input  wire logic       active,
    // Switch enables, one per input.
    output logic [7:0]      chanEnable
);
    typedef struct packed {
        logic [7:0] en;
    } acs_route_t;

    acs_route_t st;
    acs_route_t next_st;

    // Reserved codes open every switch so no input leaks into the modulator.
    always_comb begin
        next_st.en = 8'h00;
        if (active && !inputSelect[3]) begin
            next_st.en = 8'h01 << inputSelect[2:0];
        end
    end

    // Switches start open out of reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '{en: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    assign chanEnable = st.en;
endmodule
`default_nettype wire

// ==== rtl/acs_result_store.sv ====
// Result holding registers with a coherent low-bits shadow.
// Assumes capture is a one-cycle pulse at the end of a conversion.
`timescale 1ns/1ns
`default_nettype none
module acs_result_store (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Capture from the filter.
    input  wire logic                 capture,
    input  wire acs_pkg::acs_fe_data_t feData,
    // Register read side.
    input  wire logic                 highRead,
    output logic [7:0]                resultHighByte,
    output logic [7:0]                resultLowBits
);
    typedef struct packed {
        logic [acs_pkg::RAW_W-1:0] raw;
        logic                      ovf;
        logic [7:0]                shadow;
    } acs_store_t;

    acs_store_t st;
    acs_store_t next_st;
    logic [7:0] liveLow;

    // Low register image: raw bits on top, flag at the bottom, zeros between.
    always_comb begin
        liveLow = 8'h00;
        liveLow[7:acs_pkg::LO_RAW_LSB] = st.raw[4:0];
        liveLow[acs_pkg::OVF_BIT] = st.ovf;
    end

    // New samples overwrite; the shadow moves only on a high-byte read.
    always_comb begin
        next_st = st;
        if (capture) begin
            next_st.raw = feData.sample;
            next_st.ovf = feData.overflow;
        end
        if (highRead) begin
            next_st.shadow = liveLow;
        end
    end

    // Result contents are cleared so reads after reset are defined.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign resultHighByte = st.raw[acs_pkg::RAW_W-1:5];
    assign resultLowBits  = st.shadow;
endmodule
`default_nettype wire

// ==== rtl/acs_sequencer.sv ====
// Conversion sequencer for a sigma-delta converter, APB register slave.
// Assumes a single 10 MHz clock and a filter whose sample is valid at the
// cycle a conversion phase ends.
//
// Summary of operation
// - Power down after 160 idle cycles.
// - Power-up takes 40 cycles before converting.
// - Single conversion lasts 5129 cycles.
// - Start bit reads one while converting.
// - Result lands in high byte and low top.
// - Single mode converts once, then stops.
// - Repeat bit selects single or continuous.
// - Four-bit select routes one of eight inputs.
// - Continuous clears start after first result.
// - Continuous results every 256 cycles.
// - Interrupt pulse after every conversion.
// - No interrupt while disabled; pending kept. Code keeps no pending request; it is dropped.
// - Result is signed two's complement.
// - Thirteen raw bits, two for compensation.
// - Two level bits form one reference code.
// - One write to register 0 acts together.
// - Start one restarts; start zero ignored.
// - High byte read latches low bits.
// - Low register carries filter overflow flag.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer #(
    parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Analog front end.
    output acs_pkg::acs_fe_ctl_t      feCtl,
    output logic [7:0]                chanEnable,
    input  wire acs_pkg::acs_fe_data_t feData,
    // Request to the interrupt controller.
    output logic                      convIrq
);
    localparam logic [12:0] PU_LAST   = 13'(acs_pkg::POWERUP_CYCLES - 1);
    localparam logic [12:0] IDLE_LAST = 13'(acs_pkg::IDLE_CYCLES - 1);
    localparam logic [12:0] CONV_LAST = 13'(CONV_CYCLES - 1);
    localparam logic [12:0] REP_LAST  = 13'(acs_pkg::REPEAT_CYCLES - 1);

    typedef struct packed {
        acs_pkg::acs_phase_t  phase;
        logic [12:0]          dwell;
        logic                 powered;
        logic                 go;
        logic                 refLo;
        logic                 pinDrive;
        logic                 repeatSel;
        logic [3:0]           inputSel;
        logic [7:0]           ctl1;
        logic                 enable;
        logic                 irq;
        logic                 capture;
        logic                 ack;
        logic                 err;
        logic [31:0]          rdata;
        acs_pkg::acs_fe_ctl_t fe;
    } acs_seq_t;

    acs_seq_t    st;
    acs_seq_t    next_st;
    logic        access;
    logic        done;
    logic        wrDone;
    logic        highRead;
    logic        goWrite;
    logic        hitCtl0;
    logic        hitCtl1;
    logic        hitHi;
    logic        hitLo;
    logic        hitStat;
    logic [7:0]  resultHigh;
    logic [7:0]  resultLow;
    logic [7:0]  readByte;

    // Address decode; an unmapped address answers with pslverr.
    always_comb begin
        hitCtl0 = paddr == acs_pkg::acs_byte_addr(acs_pkg::IDX_CTL0);
        hitCtl1 = paddr == acs_pkg::acs_byte_addr(acs_pkg::IDX_CTL1);
        hitHi   = paddr == acs_pkg::acs_byte_addr(acs_pkg::IDX_DATA_HI);
        hitLo   = paddr == acs_pkg::acs_byte_addr(acs_pkg::IDX_DATA_LO);
        hitStat = paddr == acs_pkg::acs_byte_addr(acs_pkg::IDX_STAT);
    end

    // A transfer completes on the edge where the registered pready is high.
    assign access   = psel && penable;
    assign done     = access && st.ack;
    assign wrDone   = done && pwrite && !st.err;
    // The low image is latched on the edge that captures the high byte, so
    // a result landing between the two edges cannot split the pair.
    assign highRead = access && !st.ack && !pwrite && hitHi;
    assign goWrite  = wrDone && hitCtl0 && pwdata[acs_pkg::GO_BIT];

    // Read image of the addressed register, zero above bit 7.
    always_comb begin
        readByte = 8'h00;
        if (hitCtl0) begin
            readByte = {st.go, st.refLo, st.pinDrive, st.repeatSel,
                        st.inputSel};
        end else if (hitCtl1) begin
            readByte = st.ctl1;
        end else if (hitHi) begin
            readByte = resultHigh;
        end else if (hitLo) begin
            readByte = resultLow;
        end else if (hitStat) begin
            readByte[acs_pkg::EN_BIT]   = st.enable;
            readByte[acs_pkg::PWR_BIT]  = st.powered;
            readByte[acs_pkg::BUSY_BIT] = st.fe.run;
        end
    end

    // Next state: bus answer, phase timing, then software writes on top,
    // so a start written in the completion cycle wins over the clear.
    always_comb begin
        next_st = st;
        next_st.irq = 1'b0;
        next_st.capture = 1'b0;
        next_st.dwell = st.dwell + 13'h0001;

        // One wait state keeps every bus output on a flip-flop.
        next_st.ack = access && !st.ack;
        if (access && !st.ack) begin
            next_st.rdata = {24'h000000, readByte};
            next_st.err = !(hitCtl0 || hitCtl1 || hitHi || hitLo || hitStat);
        end

        unique case (st.phase)
            acs_pkg::PH_IDLE: begin
                if (st.powered && st.dwell == IDLE_LAST) begin
                    next_st.powered = 1'b0;
                end
            end
            acs_pkg::PH_POWERUP: begin
                if (st.dwell == PU_LAST) begin
                    next_st.powered = 1'b1;
                    next_st.phase = acs_pkg::PH_CONVERT;
                    next_st.dwell = 13'h0000;
                end
            end
            acs_pkg::PH_CONVERT: begin
                if (st.dwell == CONV_LAST) begin
                    next_st.capture = 1'b1;
                    next_st.irq = st.enable;
                    next_st.go = 1'b0;
                    next_st.dwell = 13'h0000;
                    // Repeat bit picks single or continuous.
                    if (st.repeatSel) begin
                        next_st.phase = acs_pkg::PH_REPEAT;
                    end else begin
                        next_st.phase = acs_pkg::PH_IDLE;
                    end
                end
            end
            acs_pkg::PH_REPEAT: begin
                if (!st.repeatSel) begin
                    next_st.phase = acs_pkg::PH_IDLE;
                    next_st.dwell = 13'h0000;
                end else if (st.dwell == REP_LAST) begin
                    next_st.capture = 1'b1;
                    next_st.irq = st.enable;
                    next_st.dwell = 13'h0000;
                end
            end
        endcase

        // Register writes; all control 0 fields change in the same edge.
        if (wrDone && hitCtl0) begin
            next_st.refLo = pwdata[acs_pkg::REF_LO_BIT];
            next_st.pinDrive = pwdata[acs_pkg::PIN_DRV_BIT];
            next_st.repeatSel = pwdata[acs_pkg::REPEAT_BIT];
            next_st.inputSel = pwdata[acs_pkg::SEL_MSB:0];
        end
        if (goWrite) begin
            next_st.go = 1'b1;
            next_st.dwell = 13'h0000;
            if (next_st.powered) begin
                next_st.phase = acs_pkg::PH_CONVERT;
            end else begin
                next_st.phase = acs_pkg::PH_POWERUP;
            end
        end
        if (wrDone && hitCtl1) begin
            next_st.ctl1 = pwdata[7:0];
        end
        if (wrDone && hitStat) begin
            next_st.enable = pwdata[acs_pkg::EN_BIT];
        end

        // Front-end controls follow the phase registered alongside it.
        next_st.fe.refCode = {next_st.ctl1[acs_pkg::REF_HI_BIT],
                              next_st.refLo};
        next_st.fe.refPinDrive = next_st.pinDrive;
        next_st.fe.powerOn = next_st.powered ||
                             next_st.phase == acs_pkg::PH_POWERUP;
        next_st.fe.run = next_st.phase == acs_pkg::PH_CONVERT ||
                         next_st.phase == acs_pkg::PH_REPEAT;
    end

    // Reset leaves the sequencer idle and the converter powered down.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
            st.phase <= acs_pkg::PH_IDLE;
            st.ctl1 <= acs_pkg::CTL1_RESET;
            st.enable <= acs_pkg::STAT_RESET[acs_pkg::EN_BIT];
            st.fe.refCode <= {acs_pkg::CTL1_RESET[acs_pkg::REF_HI_BIT],
                              acs_pkg::CTL0_RESET[acs_pkg::REF_LO_BIT]};
        end else begin
            st <= next_st;
        end
    end

    // Switch decoder; reserved codes open every switch.
    acs_chan_route u_route (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .inputSelect (st.inputSel),
        .active      (st.fe.powerOn),
        .chanEnable  (chanEnable)
    );

    // Result registers and the coherent low-bits shadow.
    acs_result_store u_store (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .capture        (st.capture),
        .feData         (feData),
        .highRead       (highRead),
        .resultHighByte (resultHigh),
        .resultLowBits  (resultLow)
    );

    assign prdata  = st.rdata;
    assign pready  = st.ack;
    assign pslverr = st.err;
    assign feCtl   = st.fe;
    assign convIrq = st.irq;

    // Idle powered converter drops power after exactly 160 cycles.
    property p_powerdown;
        @(posedge mclk) disable iff (!rst_n)
        (st.phase == acs_pkg::PH_IDLE && st.powered &&
         st.dwell == IDLE_LAST && !goWrite) |=> !st.powered;
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("Converter did not power down after idle time.");

    // Power-up holds for 40 cycles and then hands over to converting.
    property p_powerup;
        @(posedge mclk) disable iff (!rst_n)
        (st.phase == acs_pkg::PH_POWERUP && !goWrite) |=>
            (($past(st.dwell) == PU_LAST) ==
             (st.phase == acs_pkg::PH_CONVERT && st.powered));
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("Power-up phase length is wrong.");

    // The converting phase ends exactly at the conversion length.
    property p_convlen;
        @(posedge mclk) disable iff (!rst_n)
        (st.phase == acs_pkg::PH_CONVERT && !goWrite) |=>
            ((st.phase != acs_pkg::PH_CONVERT) ==
             ($past(st.dwell) == CONV_LAST));
    endproperty
    a_convlen: assert property (p_convlen)
        else $error("Conversion length is wrong.");

    // Start bit is high throughout the first conversion.
    property p_gohigh;
        @(posedge mclk) disable iff (!rst_n)
        st.phase == acs_pkg::PH_CONVERT |-> st.go && feCtl.run;
    endproperty
    a_gohigh: assert property (p_gohigh)
        else $error("Start bit low during a conversion.");

    // Single mode completion returns to idle with start cleared.
    property p_single;
        @(posedge mclk) disable iff (!rst_n)
        (st.phase == acs_pkg::PH_CONVERT && st.dwell == CONV_LAST &&
         !st.repeatSel && !goWrite) |=>
            st.phase == acs_pkg::PH_IDLE && !st.go && st.capture;
    endproperty
    a_single: assert property (p_single)
        else $error("Single conversion did not stop cleanly.");

    // Start stays low through every repeat period.
    property p_repeatgo;
        @(posedge mclk) disable iff (!rst_n)
        (st.phase == acs_pkg::PH_REPEAT && !goWrite) |=> !st.go;
    endproperty
    a_repeatgo: assert property (p_repeatgo)
        else $error("Start bit set during continuous results.");

    // A repeat period of 256 cycles ends in a capture, and in a request if enabled.
    property p_period;
        @(posedge mclk) disable iff (!rst_n)
        (st.phase == acs_pkg::PH_REPEAT && st.repeatSel &&
         st.dwell == REP_LAST && !goWrite) |=>
            st.capture && (convIrq == $past(st.enable));
    endproperty
    a_period: assert property (p_period)
        else $error("Repeat result missing at period end.");

    // Requests come only with a capture and only while enabled.
    property p_irqgate;
        @(posedge mclk) disable iff (!rst_n)
        convIrq |-> st.capture && $past(st.enable);
    endproperty
    a_irqgate: assert property (p_irqgate)
        else $error("Interrupt request without an enabled completion.");

    // A high-byte read freezes the low image for the next read.
    property p_latch;
        @(posedge mclk) disable iff (!rst_n)
        highRead |=> resultLow == $past(u_store.liveLow);
    endproperty
    a_latch: assert property (p_latch)
        else $error("Low bits not latched by high-byte read.");

    // A start write always begins a fresh phase from its first cycle.
    property p_restart;
        @(posedge mclk) disable iff (!rst_n)
        goWrite |=> st.go && st.dwell == 13'h0000 &&
            (st.phase == acs_pkg::PH_CONVERT ||
             st.phase == acs_pkg::PH_POWERUP);
    endproperty
    a_restart: assert property (p_restart)
        else $error("Start write did not restart the conversion.");

    // A request while powered down goes through power-up first.
    property p_wakeup;
        @(posedge mclk) disable iff (!rst_n)
        (goWrite && !st.powered && st.phase == acs_pkg::PH_IDLE) |=>
            st.phase == acs_pkg::PH_POWERUP && !st.powered;
    endproperty
    a_wakeup: assert property (p_wakeup)
        else $error("Conversion started without powering up.");
endmodule
`default_nettype wire

// ==== verification/acs_fe_model.sv ====
// Behavioural modulator and decimation filter facing the sequencer.
// Assumes the bench supplies the word for the next conversion on nextData.
`timescale 1ns/1ns
`default_nettype none
module acs_fe_model (
    // Clock.
    input  wire logic                  mclk,
    // Controls from the sequencer.
    input  wire acs_pkg::acs_fe_ctl_t  feCtl,
    // Word the bench wants converted next.
    input  wire acs_pkg::acs_fe_data_t nextData,
    // Filter output.
    output acs_pkg::acs_fe_data_t      feData
);
    acs_pkg::acs_fe_data_t held;
    logic                  runQ;
    initial begin
        held = '0;
        runQ = 1'b0;
        feData = '0;
    end
    // A word is frozen when a run starts; while unpowered the output toggles
    // every cycle, so a stale word cannot pass for a fresh one.
    always @(posedge mclk) begin
        runQ <= feCtl.run;
        if (feCtl.run && !runQ) begin
            held <= nextData;
        end
        if (!feCtl.powerOn) begin
            feData <= ~feData;
        end else begin
            feData <= (feCtl.run && !runQ) ? nextData : held;
        end
    end
endmodule
`default_nettype wire

// ==== verification/adc_conversion_sequencer_tb_top.sv ====
// Self-checking bench for the conversion sequencer, driven over APB.
// Assumes the front end model and a shortened conversion length.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_tb_top;
    localparam int CONV = 60;
    localparam int PUP  = acs_pkg::POWERUP_CYCLES;
    logic                  mclk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [15:0]           paddr = 16'h0000;
    logic [31:0]           pwdata = 32'h00000000;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  convIrq;
    logic [7:0]            chanEnable;
    acs_pkg::acs_fe_ctl_t  feCtl;
    acs_pkg::acs_fe_data_t feData;
    acs_pkg::acs_fe_data_t nextData = '0;
    int                    failures = 0;
    int                    total_checks = 0;
    int                    cyc = 0;
    int                    takeCyc = 0;
    int                    n;
    logic [31:0]           rd;
    logic [31:0]           oldLow;
    logic                  err;

    acs_sequencer #(.CONV_CYCLES(CONV)) DUT (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .feCtl(feCtl), .chanEnable(chanEnable),
        .feData(feData), .convIrq(convIrq));
    acs_fe_model FE (.mclk(mclk), .feCtl(feCtl), .nextData(nextData),
        .feData(feData));

    // Clock generation, 100 ns period.
    initial begin
        forever #50 mclk = ~mclk;
    end

    // Cycle count; a hang is cut short well beyond the expected run length.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] idx,
                       input logic [7:0] wd);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        if (wr) begin
            takeCyc = cyc + 1; // The count updates at this same edge.
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] idx, input logic [31:0] exp,
                       input string name);
        apb(1'b0, idx, 8'h00);
        chk(name, exp, rd);
    endtask

    // Cycles from the last take edge to the completion request.
    task automatic waitIrq(output int d);
        do begin
            @(posedge mclk);
            #1;
        end while (convIrq !== 1'b1 && cyc - takeCyc < 2000);
        d = cyc - takeCyc;
    endtask

    task automatic countIrq(input int len, output int k);
        k = 0;
        repeat (len) begin
            @(posedge mclk);
            #1;
            if (convIrq === 1'b1) k++;
        end
    endtask

    task automatic chkResult();
        rdc(acs_pkg::IDX_DATA_HI, {24'h0, nextData.sample[12:5]}, "high");
        rdc(acs_pkg::IDX_DATA_LO, {24'h0, nextData.sample[4:0], 2'b00,
            nextData.overflow}, "low");
    endtask

    // One single-shot conversion: go bit, routing and completion time.
    task automatic convert(input logic [3:0] sel, input int expN);
        int d;
        nextData = {13'($urandom), 1'($urandom)};
        apb(1'b1, acs_pkg::IDX_CTL0, {4'h8, sel});
        rdc(acs_pkg::IDX_CTL0, {24'h0, 4'h8, sel}, "go busy");
        repeat (PUP + 5) @(posedge mclk);
        #1;
        chk("route", sel < 8 ? 32'(1) << sel : 0, {24'h0, chanEnable});
        waitIrq(d);
        chk("done delay", expN, d);
        rdc(acs_pkg::IDX_CTL0, {24'h0, 4'h0, sel}, "go done");
    endtask

    initial begin
        void'($urandom(76004));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk("fe reset", 32'h10, {27'h0, feCtl});
        rdc(acs_pkg::IDX_CTL0, 32'h00, "ctl0 reset");
        rdc(acs_pkg::IDX_CTL1, 32'h80, "ctl1 reset");
        rdc(acs_pkg::IDX_STAT, 32'h01, "status reset");
        apb(1'b0, 12'hF75, 8'h00);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test reset done");
        // Every input, first from power-down, then powered; two reserved codes.
        for (int c = 0; c < 10; c++) begin
            convert(c == 9 ? 4'hB : 4'(c), (c == 0 ? PUP : 0) + CONV);
            chkResult();
        end
        oldLow = rd;
        convert(4'h2, CONV);
        rdc(acs_pkg::IDX_DATA_LO, oldLow, "latched low");
        chkResult();
        $display("test single done");
        apb(1'b1, acs_pkg::IDX_CTL0, 8'h83);
        repeat (20) @(posedge mclk);
        convert(4'h3, CONV);
        apb(1'b1, acs_pkg::IDX_STAT, 8'h00);
        apb(1'b1, acs_pkg::IDX_CTL0, 8'h81);
        countIrq(CONV + 50, n);
        chk("irq disabled", 0, n);
        apb(1'b1, acs_pkg::IDX_STAT, 8'h01);
        $display("test restart and disable done");
        nextData = {13'($urandom), 1'($urandom)};
        apb(1'b1, acs_pkg::IDX_CTL0, 8'h94);
        waitIrq(n);
        chk("first repeat", CONV, n);
        takeCyc = cyc;
        rdc(acs_pkg::IDX_CTL0, 32'h14, "go repeat");
        for (int k = 0; k < 3; k++) begin
            waitIrq(n);
            chk("period", 256, n);
            takeCyc = cyc;
        end
        chkResult();
        apb(1'b1, acs_pkg::IDX_CTL0, 8'h04);
        countIrq(300, n);
        chk("stopped", 0, n);
        $display("test continuous done");
        rdc(acs_pkg::IDX_STAT, 32'h01, "powered down");
        convert(4'h5, PUP + CONV);
        countIrq(100, n);
        rdc(acs_pkg::IDX_STAT, 32'h03, "still powered");
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, acs_pkg::IDX_CTL1, {r[1], 7'h00});
            apb(1'b1, acs_pkg::IDX_CTL0, {1'b0, r[0], r != 0, 5'h00});
            @(posedge mclk);
            #1;
            chk("ref", {29'h0, 2'(r), r != 0},
                {29'h0, feCtl.refCode, feCtl.refPinDrive});
        end
        $display("test power and reference done");
        stop_test();
    end
endmodule
`default_nettype wire
